// ---- rtl/sar_adc_map.svh ----
// register map, field positions, reset values and timing counts of the sar converter control
// What this block does
// - A nonzero clock divider gives a sar clock period of 2*(divider+1) system clocks.
// - A zero clock divider runs the sar clock at the full system clock rate.
// - Gain select 000/001/010/011/10x/11x decodes to gain 1/2/4/8/16/0.5.
// - With the enable bit clear the converter is shut down and starts nothing.
// - With track mode clear and the converter on, tracking runs except while converting.
// - The busy bit reads 1 while timed tracking or a conversion runs and 0 otherwise.
// - The done flag is set as a completed conversion drops busy, not on shutdown, and only software clears it.
// - Writing 1 to busy starts a conversion only in start mode 00; writing 0 does nothing.
// - With track mode clear, start mode 00/01/10/11 picks busy write/timer 3/pin rise/timer 2.
// - With track mode set and start mode 00, 01 or 11, the event opens 3 sar clocks of tracking.
// - With track mode set and start mode 10, tracking follows the low pin, conversion its rise.
// - A window match sets the window flag, which stays until software clears it.
// - Right justified, the result sits in high bits 1:0 and the low byte, sign or zero above.
// - Left justified, the result fills the high byte and low bits 7:6, low bits 5:0 read 0.
// - Single-ended codes are unsigned, differential codes are two's complement.
// - A set pair bit makes that input pair differential and so turns on sign extension.
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define SAR_CFG_ADDR 8'hBC
`define SAR_CTL_ADDR 8'hE8
`define RES_HIGH_ADDR 8'hBF
`define RES_LOW_ADDR 8'hBE
// ----------------------------------------
// reset values
// ----------------------------------------
`define CFG_RESET 8'hF8
`define CTL_RESET 8'h00
`define RES_RESET 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG_DIV_MSB 7
`define CFG_DIV_LSB 3
`define CFG_GAIN_MSB 2
`define CFG_GAIN_LSB 0
`define CTL_EN_BIT 7
`define CTL_TM_BIT 6
`define CTL_DONE_BIT 5
`define CTL_BUSY_BIT 4
`define CTL_CM_MSB 3
`define CTL_CM_LSB 2
`define CTL_WIN_BIT 1
`define CTL_LJST_BIT 0
// ----------------------------------------
// timing counts in sar clocks
// ----------------------------------------
`define TRACK_SAR_CLOCKS 5'd3
`define CONV_SAR_CLOCKS 5'd16
`endif

// ---- rtl/sar_adc_pkg.sv ----
// types shared by the sar converter control modules
package sar_adc_pkg;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_IDLE = 2'b01,
      ST_TRACK = 2'b10,
      ST_CONVERT = 2'b11
   } conv_state_e;
   typedef enum logic [1:0] {
      SRC_SOFTWARE = 2'b00,
      SRC_TIMER3 = 2'b01,
      SRC_PIN = 2'b10,
      SRC_TIMER2 = 2'b11
   } start_src_e;
   typedef struct packed {
      logic [5:0] count;
   } divider_state_s;
endpackage : sar_adc_pkg

// ---- rtl/sar_core_if.sv ----
// signals between the control, the sar clock divider and the result formatter
`timescale 1ns/1ps
`default_nettype none
interface sar_core_if;
   logic [4:0] divider;
   logic run;
   logic tick;
   logic [9:0] raw;
   logic left_justify;
   logic differential;
   logic [7:0] high;
   logic [7:0] low;
   modport control (output divider, run, raw, left_justify, differential,
                    input tick, high, low);
   modport divider_side (input divider, run, output tick);
   modport format_side (input raw, left_justify, differential, output high, low);
endinterface : sar_core_if
`default_nettype wire

// ---- rtl/sar_clock_divider.sv ----
// sar clock enable derived from the system clock
`timescale 1ns/1ps
`default_nettype none
module sar_clock_divider (
   // system
   input wire logic clk,
   input wire logic rst,
   // control side
   sar_core_if.divider_side core
);
   sar_adc_pkg::divider_state_s st;
   sar_adc_pkg::divider_state_s next_st;
   logic [5:0] last;

   assign last = {core.divider, 1'b1};
   // one tick per period of 2*(divider+1) clocks, or every clock at zero
   assign core.tick = core.run && ((core.divider == 5'h00) || (st.count == last));

   always_comb begin
      next_st = st;
      if (!core.run || core.tick) begin
         next_st.count = 6'h00;
      end else begin
         next_st.count = st.count + 6'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : sar_clock_divider
`default_nettype wire

// ---- rtl/sar_result_formatter.sv ----
// places the 10-bit code in the two result bytes
`timescale 1ns/1ps
`default_nettype none
module sar_result_formatter (
   // control side
   sar_core_if.format_side core
);
   logic fill;

   // differential codes are two's complement and carry their sign upward
   assign fill = core.differential & core.raw[9];

   always_comb begin
      if (core.left_justify) begin
         core.high = core.raw[9:2];
         core.low = {core.raw[1:0], 6'h00};
      end else begin
         core.high = {{6{fill}}, core.raw[9:8]};
         core.low = core.raw[7:0];
      end
   end
endmodule : sar_result_formatter
`default_nettype wire

// ---- rtl/sar_adc_conversion_control.sv ----
// sar converter control: registers, start sequencing and result loading
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_map.svh"
module sar_adc_conversion_control (
   // system
   input wire logic clk,
   input wire logic rst,
   // special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   output logic [7:0] sfr_rdata,
   // start sources
   input wire logic timer3_overflow,
   input wire logic timer2_overflow,
   input wire logic external_convert_start,
   // input multiplexer state
   input wire logic [3:0] input_pair_config,
   input wire logic [3:0] input_channel_select,
   // window comparator
   input wire logic window_match,
   // analog core
   input wire logic [9:0] core_result,
   output logic converter_powered,
   output logic core_track,
   output logic core_convert,
   output logic sar_clock_tick,
   output logic [5:0] amplifier_gain_x2
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   // software fields, then sequencing, then registered outputs
   typedef struct packed {
      logic [4:0] sar_clock_divider;
      logic [2:0] amplifier_gain_select;
      logic converter_enable;
      logic track_mode_select;
      logic conversion_done_flag;
      logic [1:0] start_source_select;
      logic window_match_flag;
      logic left_justify_select;
      logic [7:0] result_high_byte;
      logic [7:0] result_low_byte;
      sar_adc_pkg::conv_state_e phase;
      logic [4:0] tick_count;
      logic pin_s1;
      logic pin_s2;
      logic pin_s3;
      logic pin_level;
      logic [7:0] rdata;
      logic [5:0] gain_x2;
      logic track;
   } ctrl_state_s;

   localparam logic [7:0] CFG_INIT = `CFG_RESET;
   localparam logic [7:0] CTL_INIT = `CTL_RESET;

   // reset image of both registers and a sequencer in ST_OFF
   localparam ctrl_state_s RESET_STATE = '{
      sar_clock_divider: CFG_INIT[`CFG_DIV_MSB:`CFG_DIV_LSB],
      amplifier_gain_select: CFG_INIT[`CFG_GAIN_MSB:`CFG_GAIN_LSB],
      converter_enable: CTL_INIT[`CTL_EN_BIT],
      track_mode_select: CTL_INIT[`CTL_TM_BIT],
      conversion_done_flag: CTL_INIT[`CTL_DONE_BIT],
      start_source_select: CTL_INIT[`CTL_CM_MSB:`CTL_CM_LSB],
      window_match_flag: CTL_INIT[`CTL_WIN_BIT],
      left_justify_select: CTL_INIT[`CTL_LJST_BIT],
      result_high_byte: `RES_RESET,
      result_low_byte: `RES_RESET,
      phase: sar_adc_pkg::ST_OFF,
      tick_count: 5'h00,
      // pin stages start at the idle high level: no false rise after reset
      pin_s1: 1'b1,
      pin_s2: 1'b1,
      pin_s3: 1'b1,
      pin_level: 1'b1,
      rdata: 8'h00,
      gain_x2: 6'h02,
      track: 1'b0
   };

   ctrl_state_s st;
   ctrl_state_s next_st;

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // gain expressed in halves: 0.5 reads as 1
   function automatic logic [5:0] gain_in_halves(input logic [2:0] sel);
      logic [5:0] g;
      g = 6'h02;
      unique casez (sel)
         3'b000: g = 6'h02;
         3'b001: g = 6'h04;
         3'b010: g = 6'h08;
         3'b011: g = 6'h10;
         3'b10?: g = 6'h20;
         3'b11?: g = 6'h01;
      endcase
      return g;
   endfunction : gain_in_halves

   // pair bit of the selected channel; odd selects share their even neighbour's bit, selects with bit 3 set read 0
   function automatic logic pair_is_differential(input logic [3:0] chan,
                                                 input logic [3:0] pairs);
      logic d;
      d = 1'b0;
      if (!chan[3]) begin
         d = pairs[chan[2:1]];
      end
      return d;
   endfunction : pair_is_differential

   // busy covers timed tracking as well as the conversion itself
   function automatic logic phase_is_busy(input sar_adc_pkg::conv_state_e p);
      logic b;
      b = (p == sar_adc_pkg::ST_TRACK) || (p == sar_adc_pkg::ST_CONVERT);
      return b;
   endfunction : phase_is_busy

   function automatic logic [7:0] control_byte(input ctrl_state_s s);
      logic [7:0] b;
      logic busy;
      busy = phase_is_busy(s.phase);
      b = 8'h00;
      b[`CTL_EN_BIT] = s.converter_enable;
      b[`CTL_TM_BIT] = s.track_mode_select;
      b[`CTL_DONE_BIT] = s.conversion_done_flag;
      b[`CTL_BUSY_BIT] = busy;
      b[`CTL_CM_MSB:`CTL_CM_LSB] = s.start_source_select;
      b[`CTL_WIN_BIT] = s.window_match_flag;
      b[`CTL_LJST_BIT] = s.left_justify_select;
      return b;
   endfunction : control_byte

   // ----------------------------------------
   // sub-blocks
   // ----------------------------------------
   sar_core_if core_if();

   assign core_if.divider = st.sar_clock_divider;
   assign core_if.run = phase_is_busy(st.phase);
   assign core_if.raw = core_result;
   assign core_if.left_justify = st.left_justify_select;
   assign core_if.differential = pair_is_differential(input_channel_select,
                                                      input_pair_config);

   sar_clock_divider sar_clock_divider_inst (
      .clk(clk),
      .rst(rst),
      .core(core_if.divider_side)
   );

   sar_result_formatter sar_result_formatter_inst (
      .core(core_if.format_side)
   );

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic wr_cfg;
   logic wr_ctl;
   logic wr_high;
   logic wr_low;
   logic pin_stable;
   logic pin_rise;
   logic sw_start;
   logic tick;
   logic last_track_tick;
   logic last_conv_tick;

   // one write strobe per mapped register
   assign wr_cfg = sfr_wr && (sfr_addr == `SAR_CFG_ADDR);
   assign wr_ctl = sfr_wr && (sfr_addr == `SAR_CTL_ADDR);
   assign wr_high = sfr_wr && (sfr_addr == `RES_HIGH_ADDR);
   assign wr_low = sfr_wr && (sfr_addr == `RES_LOW_ADDR);

   // ----------------------------------------
   // start sources
   // ----------------------------------------
   // pin level accepted once the second and third stages agree
   assign pin_stable = (st.pin_s2 == st.pin_s3);
   assign pin_rise = pin_stable && st.pin_s3 && !st.pin_level;

   // a busy write of 1 starts only in software start mode
   assign sw_start = wr_ctl && sfr_wdata[`CTL_BUSY_BIT] &&
      (sfr_wdata[`CTL_CM_MSB:`CTL_CM_LSB] == sar_adc_pkg::SRC_SOFTWARE);

   // sar tick and the last tick of each timed phase
   assign tick = core_if.tick;
   assign last_track_tick = tick && (st.tick_count == (`TRACK_SAR_CLOCKS - 5'd1));
   assign last_conv_tick = tick && (st.tick_count == (`CONV_SAR_CLOCKS - 5'd1));

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic start_event;
   logic timed_track;

   always_comb begin
      next_st = st;
      start_event = 1'b0;
      timed_track = 1'b0;

      // pin synchroniser
      next_st.pin_s1 = external_convert_start;
      next_st.pin_s2 = st.pin_s1;
      next_st.pin_s3 = st.pin_s2;
      if (pin_stable) begin
         next_st.pin_level = st.pin_s3;
      end

      // software writes
      if (wr_cfg) begin
         next_st.sar_clock_divider = sfr_wdata[`CFG_DIV_MSB:`CFG_DIV_LSB];
         next_st.amplifier_gain_select = sfr_wdata[`CFG_GAIN_MSB:`CFG_GAIN_LSB];
      end
      if (wr_ctl) begin
         next_st.converter_enable = sfr_wdata[`CTL_EN_BIT];
         next_st.track_mode_select = sfr_wdata[`CTL_TM_BIT];
         next_st.conversion_done_flag = sfr_wdata[`CTL_DONE_BIT];
         next_st.start_source_select = sfr_wdata[`CTL_CM_MSB:`CTL_CM_LSB];
         next_st.window_match_flag = sfr_wdata[`CTL_WIN_BIT];
         next_st.left_justify_select = sfr_wdata[`CTL_LJST_BIT];
      end
      if (wr_high) begin
         next_st.result_high_byte = sfr_wdata;
      end
      if (wr_low) begin
         next_st.result_low_byte = sfr_wdata;
      end

      // start event of the selected source
      unique case (next_st.start_source_select)
         sar_adc_pkg::SRC_SOFTWARE: start_event = sw_start;
         sar_adc_pkg::SRC_TIMER3: start_event = timer3_overflow;
         sar_adc_pkg::SRC_PIN: start_event = pin_rise;
         sar_adc_pkg::SRC_TIMER2: start_event = timer2_overflow;
      endcase
      timed_track = next_st.track_mode_select &&
                    (next_st.start_source_select != sar_adc_pkg::SRC_PIN);

      // sequencing
      unique case (st.phase)
         sar_adc_pkg::ST_OFF: begin
            // enabling only powers up; a start needs a later start event
            if (next_st.converter_enable) begin
               next_st.phase = sar_adc_pkg::ST_IDLE;
            end
         end
         sar_adc_pkg::ST_IDLE: begin
            next_st.tick_count = 5'h00;
            if (start_event && timed_track) begin
               next_st.phase = sar_adc_pkg::ST_TRACK;
            end else if (start_event) begin
               next_st.phase = sar_adc_pkg::ST_CONVERT;
            end
         end
         sar_adc_pkg::ST_TRACK: begin
            if (last_track_tick) begin
               next_st.phase = sar_adc_pkg::ST_CONVERT;
               next_st.tick_count = 5'h00;
            end else if (tick) begin
               next_st.tick_count = st.tick_count + 5'd1;
            end
         end
         sar_adc_pkg::ST_CONVERT: begin
            if (last_conv_tick) begin
               // result lands in the same edge that drops busy
               next_st.result_high_byte = core_if.high;
               next_st.result_low_byte = core_if.low;
               next_st.phase = sar_adc_pkg::ST_IDLE;
               next_st.tick_count = 5'h00;
            end else if (tick) begin
               next_st.tick_count = st.tick_count + 5'd1;
            end
         end
      endcase

      // shutdown aborts whatever runs
      if (!next_st.converter_enable) begin
         next_st.phase = sar_adc_pkg::ST_OFF;
         next_st.tick_count = 5'h00;
      end

      // hardware sets win over a software clear in the same cycle
      if ((st.phase == sar_adc_pkg::ST_CONVERT) && last_conv_tick &&
          next_st.converter_enable) begin
         next_st.conversion_done_flag = 1'b1;
      end
      if (window_match) begin
         next_st.window_match_flag = 1'b1;
      end

      // analog core controls
      next_st.gain_x2 = gain_in_halves(next_st.amplifier_gain_select);
      next_st.track = 1'b0;
      if (next_st.converter_enable) begin
         if (!next_st.track_mode_select) begin
            next_st.track = (next_st.phase == sar_adc_pkg::ST_IDLE);
         end else if (next_st.start_source_select == sar_adc_pkg::SRC_PIN) begin
            next_st.track = (next_st.phase == sar_adc_pkg::ST_IDLE) &&
                            !next_st.pin_level;
         end else begin
            next_st.track = (next_st.phase == sar_adc_pkg::ST_TRACK);
         end
      end

      // register read data, one cycle after the address
      unique case (sfr_addr)
         `SAR_CFG_ADDR: next_st.rdata = {st.sar_clock_divider, st.amplifier_gain_select};
         `SAR_CTL_ADDR: next_st.rdata = control_byte(st);
         `RES_HIGH_ADDR: next_st.rdata = st.result_high_byte;
         `RES_LOW_ADDR: next_st.rdata = st.result_low_byte;
         default: next_st.rdata = 8'h00;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= RESET_STATE;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign sfr_rdata = st.rdata;
   assign converter_powered = st.converter_enable;
   assign core_track = st.track;
   assign core_convert = (st.phase == sar_adc_pkg::ST_CONVERT);
   assign sar_clock_tick = tick;
   assign amplifier_gain_x2 = st.gain_x2;
endmodule : sar_adc_conversion_control
`default_nettype wire

// ---- tb/sar_adc_conversion_control_properties.sv ----
// concurrent checks on the sar converter control ports
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control_properties (
   // system
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   // analog core
   input wire logic converter_powered,
   input wire logic core_track,
   input wire logic core_convert,
   input wire logic sar_clock_tick,
   input wire logic [5:0] amplifier_gain_x2
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   logic [4:0] div;
   logic tm;
   logic [1:0] cm;
   logic [6:0] gap;
   logic seen;
   logic [4:0] nt;
   logic [2:0] tt;
   wire cfg_wr = sfr_wr && sfr_addr == 8'hBC;
   wire ctl_wr = sfr_wr && sfr_addr == 8'hE8;
   wire [2:0] gsel = sfr_wdata[2:0];
   wire [6:0] period = (div == 5'h00) ? 7'h01 : {1'b0, div, 1'b0} + 7'h02;
   function automatic logic [5:0] gain_of(input logic [2:0] g);
      gain_of = g[2] ? (g[1] ? 6'h01 : 6'h20) : 6'h02 << g[1:0];
   endfunction : gain_of
   // last written fields, tick gap and tick counts per phase
   always_ff @(posedge clk) begin
      if (rst) begin
         div <= 5'h1F;
         tm <= 1'b0;
         cm <= 2'b00;
      end else if (cfg_wr) begin
         div <= sfr_wdata[7:3];
      end else if (ctl_wr) begin
         tm <= sfr_wdata[6];
         cm <= sfr_wdata[3:2];
      end
      gap <= sar_clock_tick ? 7'h01 : gap + 7'h01;
      seen <= core_convert && (seen || sar_clock_tick);
      nt <= core_convert ? nt + {4'h0, sar_clock_tick} : 5'h00;
      tt <= core_track ? tt + {2'h0, sar_clock_tick} : 3'h0;
   end
   a_gain_decode: assert property (cfg_wr |=> amplifier_gain_x2 == gain_of($past(gsel)))
      else $error("gain output wrong");
   a_off_idle: assert property (!converter_powered |-> !core_convert && !core_track)
      else $error("activity while shut down");
   a_track_apart: assert property (core_convert |-> !core_track)
      else $error("tracking during conversion");
   a_tick_busy: assert property (sar_clock_tick |-> core_convert || core_track)
      else $error("sar tick outside busy");
   a_tick_period: assert property (sar_clock_tick && seen |-> gap == period)
      else $error("sar tick period wrong");
   a_conv_length: assert property ($fell(core_convert) && converter_powered |-> nt == 5'd16)
      else $error("conversion tick count wrong");
   a_timed_track: assert property ($rose(core_convert) && tm && cm != 2'b10 |-> tt == 3'd3)
      else $error("timed tracking length wrong");
   a_sw_start: assert property (ctl_wr && sfr_wdata[7:2] == 6'b100100 && converter_powered
      && !core_convert && !tm |=> core_convert)
      else $error("busy write did not start");
   a_busy_refused: assert property (ctl_wr && sfr_wdata[4] && sfr_wdata[3:2] != 2'b00
      && !core_convert |=> !core_convert)
      else $error("busy write started in wrong mode");
endmodule : sar_adc_conversion_control_properties
bind sar_adc_conversion_control sar_adc_conversion_control_properties
   sar_adc_conversion_control_properties_inst (
   .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
   .converter_powered(converter_powered), .core_track(core_track),
   .core_convert(core_convert), .sar_clock_tick(sar_clock_tick),
   .amplifier_gain_x2(amplifier_gain_x2));
`default_nettype wire

// ---- tb/sar_analog_partner.sv ----
// behavioural far side: analog core code, timer overflows, start pin, window match
`timescale 1ns/1ps
`default_nettype none
module sar_analog_partner (
   // system
   input wire logic clk,
   // analog core
   input wire logic core_convert,
   output logic [9:0] core_result,
   // start events and window comparator
   output logic timer3_overflow,
   output logic timer2_overflow,
   output logic external_convert_start,
   output logic window_match
);
   logic [9:0] code = 10'h000;
   // code valid only while converting, its inverse otherwise
   assign core_result = core_convert ? code : ~code;
   initial begin
      timer3_overflow = 1'b0;
      timer2_overflow = 1'b0;
      external_convert_start = 1'b1;
      window_match = 1'b0;
   end
   // one start event of the given source, none for software source 00, called just after a falling edge
   task automatic fire(input logic [1:0] src);
      timer3_overflow = (src == 2'b01);
      timer2_overflow = (src == 2'b11);
      external_convert_start = (src != 2'b10);
      @(negedge clk);
      timer3_overflow = 1'b0;
      timer2_overflow = 1'b0;
      repeat (8) @(negedge clk); // pin held low for tracking
      external_convert_start = 1'b1;
      repeat (6) @(negedge clk);
   endtask : fire
   task automatic pulse_window();
      window_match = 1'b1;
      @(negedge clk);
      window_match = 1'b0;
   endtask : pulse_window
endmodule : sar_analog_partner
`default_nettype wire

// ---- tb/test_sar_adc_conversion_control.sv ----
// self-checking bench of the sar converter control
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_conversion_control;
   logic clk;
   logic rst;
   logic [7:0] sfr_addr;
   logic [7:0] sfr_wdata;
   logic sfr_wr;
   logic [7:0] sfr_rdata;
   logic t3, t2, pin, wm, pwr, trk, cnv, tick;
   logic [3:0] pairs;
   logic [3:0] chan;
   logic [9:0] res;
   logic [5:0] gain;
   logic [7:0] ctl;
   int mismatches = 0;
   int checks_done = 0;
   int i;
   logic [7:0] gtab [8] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h20, 8'h01, 8'h01};
   // justify, pairs, channel, code, high byte, low byte
   logic [39:0] rtab [4] = '{40'h0_1_0_200_FE_00, 40'h0_1_8_200_02_00,
      40'h0_0_0_3FF_03_FF, 40'h1_1_0_3FF_FF_C0};
   sar_adc_conversion_control sar_adc_conversion_control_inst (
      .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rdata(sfr_rdata), .timer3_overflow(t3), .timer2_overflow(t2),
      .external_convert_start(pin), .input_pair_config(pairs), .input_channel_select(chan),
      .window_match(wm), .core_result(res), .converter_powered(pwr), .core_track(trk),
      .core_convert(cnv), .sar_clock_tick(tick), .amplifier_gain_x2(gain));
   sar_analog_partner sar_analog_partner_inst (
      .clk(clk), .core_convert(cnv), .core_result(res), .timer3_overflow(t3),
      .timer2_overflow(t2), .external_convert_start(pin), .window_match(wm));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
      @(negedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr = a;
      @(negedge clk);
      check(sfr_rdata, exp);
   endtask : rd
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task automatic wait_idle();
      sfr_addr = 8'hE8;
      for (i = 0; i < 400; i++) begin
         @(negedge clk);
         if (sfr_rdata[4] === 1'b0)
            break;
      end
      if (i == 400) begin
         mismatches++;
         end_of_test();
      end
   endtask : wait_idle
   initial begin
      rst = 1'b1;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      pairs = 4'h0;
      chan = 4'h0;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      rd(8'hBC, 8'hF8);
      rd(8'hE8, 8'h00);
      rd(8'hBF, 8'h00);
      rd(8'hBE, 8'h00);
      rd(8'h55, 8'h00);
      check({2'b00, gain}, 8'h02);
      for (int g = 0; g < 8; g++) begin
         wr(8'hBC, 8'(g));
         check({2'b00, gain}, gtab[g]);
      end
      rd(8'hBC, 8'h07);
      wr(8'hE8, 8'h10);
      rd(8'hE8, 8'h00);
      check({7'h00, trk}, 8'h00);
      check({7'h00, pwr}, 8'h00);
      sar_analog_partner_inst.code = 10'h2A5;
      wr(8'hE8, 8'h80);
      check({7'h00, trk}, 8'h01);
      check({7'h00, pwr}, 8'h01);
      wr(8'hE8, 8'h90);
      check({7'h00, cnv}, 8'h01);
      check({7'h00, tick}, 8'h01);
      check({7'h00, trk}, 8'h00);
      rd(8'hE8, 8'h90);
      wait_idle();
      rd(8'hBF, 8'h02);
      rd(8'hBE, 8'hA5);
      repeat (20) @(negedge clk);
      rd(8'hE8, 8'hA0);
      for (int k = 0; k < 4; k++) begin
         pairs = rtab[k][35:32];
         chan = rtab[k][31:28];
         sar_analog_partner_inst.code = rtab[k][25:16];
         wr(8'hE8, 8'h90 | {7'h00, rtab[k][36]});
         wait_idle();
         rd(8'hBF, rtab[k][15:8]);
         rd(8'hBE, rtab[k][7:0]);
      end
      wr(8'hE8, 8'h90);
      wr(8'hE8, 8'h00);
      rd(8'hE8, 8'h00);
      wr(8'hBF, 8'h5A);
      rd(8'hBF, 8'h5A);
      sar_analog_partner_inst.pulse_window();
      repeat (5) @(negedge clk);
      rd(8'hE8, 8'h02);
      wr(8'hE8, 8'h00);
      rd(8'hE8, 8'h00);
      wr(8'hBC, 8'h08);
      wr(8'hE8, 8'h80);
      for (int m = 0; m < 8; m++) begin
         ctl = {1'b1, m[2], 2'b00, m[1:0], 2'b00};
         wr(8'hE8, ctl | 8'h10);
         rd(8'hE8, (m[1:0] == 2'b00) ? (ctl | 8'h10) : ctl);
         sar_analog_partner_inst.fire(m[1:0]);
         wait_idle();
         rd(8'hE8, ctl | 8'h20);
      end
      end_of_test();
   end
endmodule : test_sar_adc_conversion_control
`default_nettype wire
